// >>> rtl/ctbc_codec.v
/*
 * Cassette tape block codec: takes motor, read and write requests,
 * frames records as leader, sync bit, sync byte, 256-byte blocks with
 * check words and trailer, and decodes them back into memory.
 * Assumes a byte memory answering mem_rd one cycle later, and a
 * cassette input that is asynchronous to clk.
 */
//
// Behaviour
// - Read and write switch the motor on at start and off at the end.
// - A written record opens with 256 leader bytes of all ones.
// - Leader is followed by one zero sync bit and sync byte 16 hex.
// - Data goes in 256-byte blocks, each followed by a two-byte check.
// - Each bit is one square cycle: 1.0 ms for one, 0.5 ms for zero.
// - Square-wave period reloads per bit on the fly without gaps.
// - Memory bytes are serialised to tape one bit at a time.
// - A short final block is padded by repeating the last data byte.
// - After the last block a trailer of four all-ones bytes follows.
// - Read waits about 0.5 s after motor on before decoding.
// - A zero counts as sync only after a quarter-leader run of ones.
// - A wrong sync byte is discarded and leader search restarts.
// - Received bytes are stored at the address, which then increments.
// - After each 256 data bytes the check word is compared; error 01.
// - The count of bytes stored is returned, also on error.
// - Check is CRC x16+x12+x5+1, every data bit shifted through.
// - Written check word is the complement of the check register.
// - Status: 00 ok, 01 check, 02 no transitions, 04 no leader, 80 bad.
// - Any error also raises a single error indication.
// - Time-of-day interrupt is masked from the second cycle of a read to the first cycle after it.
`include "ctbc_defs.vh"

module ctbc_codec #(
    parameter [15:0] ONE_CYCLES = `CTBC_ONE_CYCLES,
    parameter [15:0] ZERO_CYCLES = `CTBC_ZERO_CYCLES,
    parameter [22:0] MOTOR_WAIT_CYCLES = `CTBC_MOTOR_WAIT_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Request
    input wire req_valid,
    input wire [7:0] req_code,
    input wire [15:0] transfer_memory_pointer,
    input wire [15:0] requested_byte_count,
    // Answer
    output reg busy,
    output reg done,
    output reg [7:0] request_and_status_byte,
    output reg [15:0] returned_byte_count,
    output reg error_flag,
    // Memory
    output reg [15:0] mem_addr,
    output reg mem_rd,
    input wire [7:0] mem_rdata,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    // Cassette
    output reg motor_on,
    output wire tape_out,
    input wire tape_in,
    // Time-of-day interrupt
    input wire timekeeping_interrupt_line,
    output reg timekeeping_interrupt_gated
);

localparam S_IDLE = 4'h0;
localparam S_WLEAD = 4'h1;
localparam S_WSBIT = 4'h2;
localparam S_WSBYTE = 4'h3;
localparam S_WDATA = 4'h4;
localparam S_WCRC1 = 4'h5;
localparam S_WCRC2 = 4'h6;
localparam S_WTRAIL = 4'h7;
localparam S_RWAIT = 4'h8;
localparam S_RLEAD = 4'h9;
localparam S_RSBYTE = 4'hA;
localparam S_RDATA = 4'hB;
localparam S_RCRC = 4'hC;

localparam [16:0] PER_SUM = {1'b0, ONE_CYCLES} + {1'b0, ZERO_CYCLES};
localparam [15:0] THRESH = PER_SUM[16:1];
localparam [16:0] PER_TWICE = {ONE_CYCLES, 1'b0};
localparam [15:0] RX_TIMEOUT = PER_TWICE[15:0];

reg [3:0] state_q;
reg [15:0] cnt_q;
reg [15:0] n_q;
reg [7:0] pos_q;
reg [3:0] bits_q;
reg [7:0] sh_q;
reg [7:0] nxt_q;
reg rd_pend_q;
reg [15:0] crc_q;
reg [15:0] rxw_q;
reg [22:0] wait_q;
reg [11:0] run_q;
reg [15:0] srch_q;
reg tx_en_q;
reg s1_q, s2_q, s3_q, lvl_q;
reg [15:0] per_q;

wire wdone;
wire rd_act = state_q[3];
wire rx_act = rd_act && (state_q != S_RWAIT);
wire rx_rise = (s2_q == s3_q) && s3_q && !lvl_q;
wire rx_bit = (per_q > THRESH);
wire rx_to = rx_act && (per_q == RX_TIMEOUT - 16'h0001);
wire crc_in = rd_act ? rx_bit : sh_q[7];
wire crc_fb = crc_q[15] ^ crc_in;
wire [15:0] crc_step = {crc_q[14:0], 1'b0} ^
                       (crc_fb ? `CTBC_CRC_POLY : 16'h0000);
wire [7:0] rx_byte = {rxw_q[6:0], rx_bit};
wire [15:0] rx_word = {rxw_q[14:0], rx_bit};
wire more_data = (n_q < cnt_q);

ctbc_wave u_wave (
    .clk(clk),
    .rst(rst),
    .en(tx_en_q),
    .period(sh_q[7] ? ONE_CYCLES : ZERO_CYCLES),
    .wave(tape_out),
    .bit_done(wdone)
);

// Three-stage input sync; a level change counts once stages 2 and 3 agree
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
        per_q <= 16'h0000;
    end
    else
    begin
        s1_q <= tape_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
            lvl_q <= s3_q;
        // Period is measured rising edge to rising edge
        if (!rx_act || rx_rise)
            per_q <= 16'h0000;
        else if (per_q != RX_TIMEOUT)
            per_q <= per_q + 16'h0001;
    end
end

task finish;
    input [7:0] st;
    begin
        done <= 1'b1;
        request_and_status_byte <= st;
        error_flag <= (st != `CTBC_ST_OK);
        returned_byte_count <= n_q;
        motor_on <= 1'b0;
        tx_en_q <= 1'b0;
        busy <= 1'b0;
        state_q <= S_IDLE;
    end
endtask

task load_data;
    begin
        sh_q <= nxt_q;
        bits_q <= 4'h7;
        if (more_data)
        begin
            n_q <= n_q + 16'h0001;
            if (n_q + 16'h0001 < cnt_q)
            begin
                mem_rd <= 1'b1;
                mem_addr <= mem_addr + 16'h0001;
            end
        end
    end
endtask

task load_const;
    input [7:0] b;
    input [3:0] nb;
    begin
        sh_q <= b;
        bits_q <= nb;
    end
endtask

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state_q <= S_IDLE;
        busy <= 1'b0;
        done <= 1'b0;
        request_and_status_byte <= `CTBC_ST_OK;
        returned_byte_count <= 16'h0000;
        error_flag <= 1'b0;
        mem_addr <= 16'h0000;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        mem_wdata <= 8'h00;
        motor_on <= 1'b0;
        timekeeping_interrupt_gated <= 1'b0;
        cnt_q <= 16'h0000;
        n_q <= 16'h0000;
        pos_q <= 8'h00;
        bits_q <= 4'h0;
        sh_q <= 8'h00;
        nxt_q <= 8'h00;
        rd_pend_q <= 1'b0;
        crc_q <= `CTBC_CRC_PRESET;
        rxw_q <= 16'h0000;
        wait_q <= 23'h000000;
        run_q <= 12'h000;
        srch_q <= 16'h0000;
        tx_en_q <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        rd_pend_q <= mem_rd;
        if (rd_pend_q)
            nxt_q <= mem_rdata;
        if (mem_wr)
            mem_addr <= mem_addr + 16'h0001;
        timekeeping_interrupt_gated <= timekeeping_interrupt_line &&
                                       !rd_act;
        case (state_q)
        S_IDLE:
            if (req_valid)
            begin
                cnt_q <= requested_byte_count;
                n_q <= 16'h0000;
                mem_addr <= transfer_memory_pointer;
                if (req_code == `CTBC_REQ_MOTOR_ON)
                begin
                    motor_on <= 1'b1;
                    done <= 1'b1;
                    request_and_status_byte <= `CTBC_ST_OK;
                    error_flag <= 1'b0;
                    returned_byte_count <= 16'h0000;
                end
                else if (req_code == `CTBC_REQ_MOTOR_OFF)
                    finish(`CTBC_ST_OK);
                else if (req_code == `CTBC_REQ_WRITE)
                begin
                    motor_on <= 1'b1;
                    busy <= 1'b1;
                    tx_en_q <= 1'b1;
                    mem_rd <= (requested_byte_count != 16'h0000);
                    load_const(`CTBC_ONES_BYTE, 4'h7);
                    pos_q <= 8'h00;
                    state_q <= S_WLEAD;
                end
                else if (req_code == `CTBC_REQ_READ)
                begin
                    motor_on <= 1'b1;
                    busy <= 1'b1;
                    wait_q <= 23'h000000;
                    state_q <= S_RWAIT;
                end
                else
                begin
                    done <= 1'b1;
                    request_and_status_byte <= `CTBC_ST_BAD_REQ;
                    error_flag <= 1'b1;
                    returned_byte_count <= 16'h0000;
                end
            end
        S_WLEAD, S_WSBIT, S_WSBYTE, S_WDATA, S_WCRC1, S_WCRC2, S_WTRAIL:
            if (wdone)
            begin
                if (state_q == S_WDATA)
                    crc_q <= crc_step;
                if (bits_q != 4'h0)
                begin
                    sh_q <= {sh_q[6:0], 1'b0};
                    bits_q <= bits_q - 4'h1;
                end
                else
                    case (state_q)
                    S_WLEAD:
                        if (pos_q == `CTBC_LEADER_LAST)
                        begin
                            load_const(`CTBC_ZERO_BYTE, 4'h0);
                            state_q <= S_WSBIT;
                        end
                        else
                        begin
                            pos_q <= pos_q + 8'h01;
                            load_const(`CTBC_ONES_BYTE, 4'h7);
                        end
                    S_WSBIT:
                    begin
                        load_const(`CTBC_SYNC_BYTE, 4'h7);
                        state_q <= S_WSBYTE;
                    end
                    S_WDATA:
                        if (pos_q == `CTBC_BLOCK_LAST)
                        begin
                            load_const(~crc_step[15:8], 4'h7);
                            state_q <= S_WCRC1;
                        end
                        else
                        begin
                            pos_q <= pos_q + 8'h01;
                            load_data;
                        end
                    S_WCRC1:
                    begin
                        load_const(~crc_q[7:0], 4'h7);
                        state_q <= S_WCRC2;
                    end
                    S_WTRAIL:
                        if (pos_q == `CTBC_TRAILER_LAST)
                            finish(`CTBC_ST_OK);
                        else
                        begin
                            pos_q <= pos_q + 8'h01;
                            load_const(`CTBC_ONES_BYTE, 4'h7);
                        end
                    default:
                        // After sync byte or a check word
                        if (!more_data)
                        begin
                            pos_q <= 8'h00;
                            load_const(`CTBC_ONES_BYTE, 4'h7);
                            state_q <= S_WTRAIL;
                        end
                        else
                        begin
                            pos_q <= 8'h00;
                            crc_q <= `CTBC_CRC_PRESET;
                            load_data;
                            state_q <= S_WDATA;
                        end
                    endcase
            end
        S_RWAIT:
            if (wait_q == MOTOR_WAIT_CYCLES - 23'h000001)
            begin
                run_q <= 12'h000;
                srch_q <= 16'h0000;
                state_q <= S_RLEAD;
            end
            else
                wait_q <= wait_q + 23'h000001;
        default:
            if (rx_to)
                finish(`CTBC_ST_NO_TRANS);
            else if (rx_rise)
            begin
                rxw_q <= rx_word;
                bits_q <= bits_q + 4'h1;
                case (state_q)
                S_RLEAD:
                begin
                    bits_q <= 4'h0;
                    srch_q <= srch_q + 16'h0001;
                    if (srch_q == `CTBC_LEAD_SEARCH_BITS)
                        finish(`CTBC_ST_NO_LEADER);
                    else if (rx_bit)
                    begin
                        if (run_q != `CTBC_LEAD_MIN_BITS)
                            run_q <= run_q + 12'h001;
                    end
                    else if (run_q == `CTBC_LEAD_MIN_BITS)
                        state_q <= S_RSBYTE;
                    else
                        run_q <= 12'h000;
                end
                S_RSBYTE:
                    if (bits_q == 4'h7)
                    begin
                        bits_q <= 4'h0;
                        pos_q <= 8'h00;
                        crc_q <= `CTBC_CRC_PRESET;
                        if (rx_byte == `CTBC_SYNC_BYTE)
                            state_q <= S_RDATA;
                        else
                        begin
                            run_q <= 12'h000;
                            srch_q <= 16'h0000;
                            state_q <= S_RLEAD;
                        end
                    end
                S_RDATA:
                begin
                    crc_q <= crc_step;
                    if (bits_q == 4'h7)
                    begin
                        bits_q <= 4'h0;
                        // Padding bytes are checked but never stored
                        if (more_data)
                        begin
                            mem_wdata <= rx_byte;
                            mem_wr <= 1'b1;
                            n_q <= n_q + 16'h0001;
                        end
                        if (pos_q == `CTBC_BLOCK_LAST)
                            state_q <= S_RCRC;
                        else
                            pos_q <= pos_q + 8'h01;
                    end
                end
                default:
                    if (bits_q == 4'hF)
                    begin
                        bits_q <= 4'h0;
                        pos_q <= 8'h00;
                        crc_q <= `CTBC_CRC_PRESET;
                        if (rx_word != ~crc_q)
                            finish(`CTBC_ST_CRC);
                        else if (!more_data)
                            finish(`CTBC_ST_OK);
                        else
                            state_q <= S_RDATA;
                    end
                endcase
            end
        endcase
    end
end

endmodule // ctbc_codec

// >>> rtl/ctbc_defs.vh
/*
 * Constants of the cassette tape block codec: bit timing, frame layout,
 * check-word polynomial, request codes and status codes.
 * Assumes a 10 MHz system clock; timing counts are in clock cycles.
 */
`ifndef CTBC_DEFS_VH
`define CTBC_DEFS_VH

`define CTBC_ONE_CYCLES 16'h2710
`define CTBC_ZERO_CYCLES 16'h1388
`define CTBC_MOTOR_WAIT_CYCLES 23'h4C4B40

`define CTBC_LEADER_LAST 8'hFF
`define CTBC_BLOCK_LAST 8'hFF
`define CTBC_TRAILER_LAST 8'h03
`define CTBC_ONES_BYTE 8'hFF
`define CTBC_SYNC_BYTE 8'h16
`define CTBC_ZERO_BYTE 8'h00
`define CTBC_LEAD_MIN_BITS 12'h200
`define CTBC_LEAD_SEARCH_BITS 16'h1000

`define CTBC_CRC_POLY 16'h1021
`define CTBC_CRC_PRESET 16'hFFFF

`define CTBC_REQ_MOTOR_ON 8'h00
`define CTBC_REQ_MOTOR_OFF 8'h01
`define CTBC_REQ_READ 8'h02
`define CTBC_REQ_WRITE 8'h03

`define CTBC_ST_OK 8'h00
`define CTBC_ST_CRC 8'h01
`define CTBC_ST_NO_TRANS 8'h02
`define CTBC_ST_NO_LEADER 8'h04
`define CTBC_ST_BAD_REQ 8'h80

`endif

// >>> rtl/ctbc_wave.v
/*
 * Square-wave bit-cell generator: one full cycle per bit, high for the
 * first half, with the period reloaded at the start of every cycle.
 * Assumes the caller updates period in the cycle bit_done is high.
 */
module ctbc_wave (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire en,
    input wire [15:0] period,
    // Output
    output wire wave,
    output wire bit_done
);

reg [15:0] per_q;
reg [15:0] cnt_q;
reg wave_q;

assign wave = wave_q;
assign bit_done = en && (cnt_q != 16'h0000) &&
                  (cnt_q == per_q - 16'h0001);

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        per_q <= 16'h0000;
        cnt_q <= 16'h0000;
        wave_q <= 1'b0;
    end
    else if (!en)
    begin
        per_q <= period;
        cnt_q <= 16'h0000;
        wave_q <= 1'b0;
    end
    else if (cnt_q == 16'h0000)
    begin
        // Reload on the fly so consecutive bits abut with no gap
        per_q <= period;
        cnt_q <= 16'h0001;
        wave_q <= 1'b1;
    end
    else if (bit_done)
    begin
        cnt_q <= 16'h0000;
    end
    else
    begin
        cnt_q <= cnt_q + 16'h0001;
        if (cnt_q == {1'b0, per_q[15:1]})
            wave_q <= 1'b0;
    end
end

endmodule // ctbc_wave

// >>> testbench/ctbc_codec_chk.sv
/* Port assertions for ctbc_codec.
   Assumes one clock domain; bound to every codec below. */
module ctbc_codec_chk #(
    parameter [15:0] ONE_CYCLES = 16'h2710,
    parameter [15:0] ZERO_CYCLES = 16'h1388,
    parameter [22:0] MOTOR_WAIT_CYCLES = 23'h4C4B40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request and answer
    input wire logic req_valid,
    input wire logic [7:0] req_code,
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] request_and_status_byte,
    input wire logic error_flag,
    // Memory and cassette
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr,
    input wire logic motor_on,
    input wire logic tape_out,
    // Tick
    input wire logic timekeeping_interrupt_line,
    input wire logic timekeeping_interrupt_gated
);
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    logic [15:0] last_q;
    logic rd_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Phase lengths of the tape square wave
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hi_q <= 16'h0000;
            lo_q <= 16'h0000;
            last_q <= 16'h0000;
            rd_q <= 1'b0;
        end
        else
        begin
            hi_q <= tape_out ? hi_q + 16'h0001 : 16'h0000;
            lo_q <= tape_out ? 16'h0000 : lo_q + 16'h0001;
            if (!busy)
                last_q <= 16'h0000;
            else if (!tape_out && hi_q != 16'h0000)
                last_q <= hi_q;
            if (req_valid && !busy && !done)
                rd_q <= (req_code == 8'h02);
        end
    end

    sequence s_take;
        req_valid && !busy && !done;
    endsequence

    chk_motor_on_req: assert property (s_take ##0 req_code == 8'h00 |=>
        done && motor_on && request_and_status_byte == 8'h00)
        else $error("motor on request not answered");
    chk_motor_off_req: assert property (s_take ##0 req_code == 8'h01
        |=> done && !motor_on)
        else $error("motor off request not answered");
    chk_bad_request: assert property (s_take ##0 req_code > 8'h03 |=>
        done && error_flag && request_and_status_byte == 8'h80)
        else $error("unknown request not refused");
    chk_xfer_start: assert property (s_take ##0 (req_code == 8'h02 ||
        req_code == 8'h03) |=> busy && motor_on && !done)
        else $error("transfer did not start motor");
    chk_xfer_end: assert property ($fell(busy) |-> done && !motor_on)
        else $error("transfer end left motor running");
    chk_error_flag: assert property (done |->
        error_flag == (request_and_status_byte != 8'h00))
        else $error("error flag disagrees with status");
    chk_status_code: assert property (done |->
        request_and_status_byte inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h80})
        else $error("status code outside the set");
    chk_addr_step: assert property (mem_wr |=>
        mem_addr == $past(mem_addr) + 16'h0001)
        else $error("address not stepped after store");
    chk_irq_masked: assert property (busy && $past(busy) && rd_q
        |-> !timekeeping_interrupt_gated)
        else $error("tick passed during read");
    chk_irq_pass: assert property (timekeeping_interrupt_line && !busy &&
        !req_valid |=> timekeeping_interrupt_gated)
        else $error("tick lost while idle");
    chk_bit_width: assert property ($fell(tape_out) |->
        hi_q == ONE_CYCLES / 2 || hi_q == ZERO_CYCLES / 2)
        else $error("bit cell of wrong length");
    chk_no_gap: assert property ($rose(tape_out) && last_q != 16'h0000
        |-> lo_q == last_q)
        else $error("gap or uneven cycle between bits");
endmodule // ctbc_codec_chk

bind ctbc_codec ctbc_codec_chk #(
    .ONE_CYCLES(ONE_CYCLES),
    .ZERO_CYCLES(ZERO_CYCLES),
    .MOTOR_WAIT_CYCLES(MOTOR_WAIT_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_code(req_code),
    .busy(busy), .done(done),
    .request_and_status_byte(request_and_status_byte),
    .error_flag(error_flag), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .motor_on(motor_on), .tape_out(tape_out),
    .timekeeping_interrupt_line(timekeeping_interrupt_line),
    .timekeeping_interrupt_gated(timekeeping_interrupt_gated)
);

// >>> testbench/ctbc_codec_test.sv
/* Self-checking bench for ctbc_codec with shortened bit timing.
   Assumes the deck model and the bound checker beside it. */
module ctbc_codec_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D0 = 2057;
    logic clk = 0, rst = 1, req_valid = 0, tick = 0, play = 0;
    logic [7:0] req_code = 0, mem_rdata = 0, st, mem_wdata;
    logic [15:0] ptr = 0, cnt = 0, skip = 0, flip = 16'hFFFF, mem_addr;
    logic busy, done, error_flag, mem_rd, mem_wr, motor_on;
    logic tape_out, tape_in, gated, was_busy = 0;
    logic [15:0] ret_cnt;
    logic [7:0] mem [0:65535];
    int errors = 0, n_compared = 0, cyc = 0, n_wr = 0, n_gated = 0;

    always #50 clk = ~clk;

    ctbc_codec #(.ONE_CYCLES(16'h0008), .ZERO_CYCLES(16'h0004),
        .MOTOR_WAIT_CYCLES(23'h000032)) dut (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_code(req_code),
        .transfer_memory_pointer(ptr), .requested_byte_count(cnt),
        .busy(busy), .done(done), .request_and_status_byte(st),
        .returned_byte_count(ret_cnt), .error_flag(error_flag),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .motor_on(motor_on),
        .tape_out(tape_out), .tape_in(tape_in),
        .timekeeping_interrupt_line(tick),
        .timekeeping_interrupt_gated(gated));

    ctbc_tape_model u_tape (.clk(clk), .motor_on(motor_on),
        .tape_out(tape_out), .tape_in(tape_in), .play(play),
        .skip(skip), .flip(flip));

    // Byte memory and a slow tick that keeps running during transfers
    always @(negedge clk)
    begin
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
        if (mem_wr)
        begin
            mem[mem_addr] <= mem_wdata;
            n_wr++;
        end
        if (gated === 1'b1 && busy && was_busy)
            n_gated++;
        was_busy <= busy;
        tick <= (cyc % 37 == 0);
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            errors++;
            end_sim();
        end
    end

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task request(input logic [7:0] c, input logic [15:0] p,
        input logic [15:0] n);
        int k;
        @(negedge clk);
        req_code = c;
        ptr = p;
        cnt = n;
        req_valid = 1;
        @(negedge clk);
        req_valid = 0;
        k = 0;
        while (done !== 1'b1 && k < 120000)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 120000)
            errors++;
    endtask

    function automatic logic [7:0] tbyte(input int at);
        logic [7:0] v;
        v = 8'h00;
        for (int j = 0; j < 8; j++)
            v = {v[6:0], u_tape.hw[at + j] == 4};
        return v;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
        input logic [7:0] d);
        logic fb;
        for (int j = 7; j >= 0; j--)
        begin
            fb = c[15] ^ d[j];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction

    task test_cmds;
        request(8'h00, 16'h0000, 16'h0000);
        check(motor_on, 16'h0001);
        request(8'h01, 16'h0000, 16'h0000);
        check(motor_on, 16'h0000);
        request(8'h07, 16'h0000, 16'h0000);
        check(st, 16'h0080);
        check(error_flag, 16'h0001);
        $display("test_cmds done");
    endtask

    task test_write;
        logic [15:0] c;
        logic [7:0] e;
        int bad;
        mem[16'h1000] = 8'h80;
        mem[16'h1001] = 8'h01;
        u_tape.hw.delete();
        request(8'h03, 16'h1000, 16'h0002);
        check(st, 16'h0000);
        check(ret_cnt, 16'h0002);
        check(motor_on, 16'h0000);
        check(16'(u_tape.hw.size()), 16'h1039);
        bad = 0;
        for (int i = 0; i < 2048; i++)
            bad += (u_tape.hw[i] != 4);
        check(16'(bad), 16'h0000);
        check(16'(u_tape.hw[2048]), 16'h0002);
        check(tbyte(2049), 16'h0016);
        c = 16'hFFFF;
        bad = 0;
        for (int k = 0; k < 256; k++)
        begin
            e = (k == 0) ? 8'h80 : 8'h01;
            c = crc_byte(c, e);
            bad += (tbyte(D0 + 8 * k) !== e);
        end
        check(16'(bad), 16'h0000);
        check({tbyte(4105), tbyte(4113)}, ~c);
        check({tbyte(4121), tbyte(4129)}, 16'hFFFF);
        check({tbyte(4137), tbyte(4145)}, 16'hFFFF);
        $display("test_write done");
    endtask

    task test_read(input logic [15:0] f, input logic [15:0] s,
        input logic [15:0] b1, input logic [15:0] n);
        mem[16'h2000] = 8'hAA;
        mem[16'h2001] = 8'hAA;
        mem[16'h2002] = 8'hAA;
        n_wr = 0;
        n_gated = 0;
        skip = (f == 16'hFFFE) ? 16'hFFFF : 16'h05DC;
        flip = f;
        play = 1;
        request(8'h02, 16'h2000, 16'h0002);
        play = 0;
        check(st, s);
        check(error_flag, 16'(s != 16'h0000));
        check(ret_cnt, n);
        check(16'(n_wr), n);
        check(mem[16'h2000], (n == 0) ? 16'h00AA : 16'h0080);
        check(mem[16'h2001], b1);
        check(mem[16'h2002], 16'h00AA);
        check(16'(n_gated), 16'h0000);
        check(motor_on, 16'h0000);
        repeat (40) @(negedge clk);
        $display("test_read done");
    endtask

    initial
    begin
        repeat (6) @(negedge clk);
        rst = 0;
        test_cmds();
        test_write();
        test_read(16'hFFFF, 16'h0000, 16'h0001, 16'h0002);
        test_read(16'(D0 + 9), 16'h0001, 16'h0041, 16'h0002);
        test_read(16'hFFFE, 16'h0002, 16'h00AA, 16'h0000);
        end_sim();
    end
endmodule // ctbc_codec_test

// >>> testbench/ctbc_tape_model.sv
/* Cassette deck model: records high-phase widths of the write head
   and plays them back on the read head while the motor runs.
   Assumes the bench selects record or play and clears the tape. */
module ctbc_tape_model (
    // Clock
    input wire logic clk,
    // Deck
    input wire logic motor_on,
    input wire logic tape_out,
    output logic tape_in,
    // Bench control
    input wire logic play,
    input wire logic [15:0] skip,
    input wire logic [15:0] flip
);
    parameter int HALF_ONE = 4;
    parameter int HALF_ZERO = 2;
    int hw[$];
    int cnt = 0;
    int w;

    // Nothing is written while the motor is stopped
    always @(posedge clk)
        if (motor_on && !play)
        begin
            if (tape_out)
                cnt++;
            else if (cnt != 0)
            begin
                hw.push_back(cnt);
                cnt = 0;
            end
        end

    // Playback may start mid-leader, as a rewound tape would
    initial
    begin
        tape_in = 1'b0;
        forever
        begin
            @(negedge clk iff (motor_on && play));
            for (int i = skip; i < hw.size() && motor_on && play; i++)
            begin
                w = hw[i];
                if (i == flip)
                    w = (w == HALF_ONE) ? HALF_ZERO : HALF_ONE;
                tape_in <= 1'b1;
                repeat (w) @(negedge clk);
                tape_in <= 1'b0;
                repeat (w) @(negedge clk);
            end
            // Head leaves the recording: a static, inverted level
            tape_in <= ~tape_in;
            @(negedge clk iff !(motor_on && play));
        end
    end
endmodule // ctbc_tape_model
